// ===== design/oxm_pkg.sv
/*
 * oxm_pkg: shared constants and types of the optical module control and
 * status block. Assumes a single 100 MHz system clock domain.
 */
package oxm_pkg;
	// two-wire device addresses (8-bit form, r/w bit clear)
	localparam logic [7:0] ADDR_ID   = 8'h00_A0;
	localparam logic [7:0] ADDR_DIAG = 8'h00_A2;
	localparam logic [7:0] OFF_TRSC  = 8'h00_6E;
	// byte 110 field positions
	localparam int BIT_SHDN_STAT = 7;
	localparam int BIT_SHDN_SOFT = 6;
	localparam int BIT_FAULT     = 2;
	localparam int BIT_LOS       = 1;
	// diagnostic measurement offsets
	localparam logic [7:0] OFF_TEMP  = 8'h00_60;
	localparam logic [7:0] OFF_VCC   = 8'h00_62;
	localparam logic [7:0] OFF_BIAS  = 8'h00_64;
	localparam logic [7:0] OFF_TXPWR = 8'h00_66;
	localparam logic [7:0] OFF_RXPWR = 8'h00_68;
	localparam int NUM_MEAS = 5;
	localparam logic [2:0] BITS_PER_BYTE_M1 = 3'h7;
	// shutdown spacing expected of the host, ms, and in cycles
	localparam int SHDN_GAP_MS = 10;
	localparam int CLK_MHZ     = 100;
	localparam int SHDN_GAP_CYC = SHDN_GAP_MS * 1000 * CLK_MHZ;

	typedef struct packed {
		logic [15:0] temp;
		logic [15:0] vcc;
		logic [15:0] bias;
		logic [15:0] tx_pwr;
		logic [15:0] rx_pwr;
	} oxm_meas_t;

	typedef struct packed {
		logic we;
		logic page;
		logic [7:0] addr;
		logic [7:0] wdata;
	} oxm_mem_req_t;

	typedef enum logic [7:0] {
		ST_IDLE  = 8'b0000_0001,
		ST_DEV   = 8'b0000_0010,
		ST_DACK  = 8'b0000_0100,
		ST_WORD  = 8'b0000_1000,
		ST_WACK  = 8'b0001_0000,
		ST_WDATA = 8'b0010_0000,
		ST_RDATA = 8'b0100_0000,
		ST_RACK  = 8'b1000_0000
	} oxm_state_t;
endpackage

// ===== design/oxm_mem.sv
/*
 * oxm_mem: two 256-byte pages (identification, diagnostics) in one array
 * with registered read data. Assumes the caller sequences its accesses.
 */
`timescale 1ns/100ps
module oxm_mem (
	input  wire logic                 clk_sys,
	input  wire oxm_pkg::oxm_mem_req_t req,
	input  wire logic                 req_valid,
	output logic [7:0]                rdata
);
	logic [7:0] store [0:511];
	wire  [8:0] index = {req.page, req.addr};

	always_ff @(posedge clk_sys) begin
		if (req_valid && req.we) begin
			store[index] <= req.wdata;
		end
		rdata <= store[index];
	end
endmodule

// ===== design/oxm_top.sv
/*
 * oxm_top: transmitter shutdown, latched laser fault, loss-of-signal mirror
 * and the two-wire serial slave of a pluggable optical module.
 * Assumes all pins are asynchronous to clk_sys; the serial clock is
 * sampled, never used as a clock.
 */
`timescale 1ns/100ps
module oxm_top (
	input  wire logic              clk_sys,
	input  wire logic              rst_b,
	input  wire logic              tx_shutdown_pin,
	input  wire logic              tx_shutdown_pin_driven,
	input  wire logic              laser_fault_det,
	input  wire logic              unsafe_power_det,
	input  wire logic              optical_input_bad,
	input  wire oxm_pkg::oxm_meas_t meas,
	input  wire logic              scl_i,
	input  wire logic              sda_i,
	output logic                   sda_o,
	output logic                   sda_oe,
	output logic                   laser_enable,
	output logic                   tx_fault,
	output logic                   tx_fault_oe,
	output logic                   receive_signal_lost
);
	// ************************************************
	// pin synchronisers
	// ************************************************
	logic [5:0] sync1;
	logic [5:0] sync2;
	wire  [5:0] raw = {unsafe_power_det, optical_input_bad, laser_fault_det,
	                   tx_shutdown_pin | ~tx_shutdown_pin_driven, scl_i, sda_i};
	always_ff @(posedge clk_sys) begin
		sync1 <= raw;
		sync2 <= sync1;
	end
	wire scl_s    = sync2[1];
	wire sda_s    = sync2[0];
	wire shdn_pin = sync2[2];
	wire fault_s  = sync2[3];
	wire los_s    = sync2[4];
	wire unsafe_s = sync2[5];

	// ************************************************
	// shutdown and fault latch
	// ************************************************
	logic soft_shdn;
	logic fault_latch;
	logic shdn_pin_q;
	wire  shdn_eff   = shdn_pin | soft_shdn;
	wire  pin_fall   = shdn_pin_q & ~shdn_pin;
	// a trip arriving with the release wins; the latch must never miss a fault
	wire  next_fault = (fault_s | unsafe_s) | (fault_latch & ~pin_fall);
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			fault_latch  <= 1'b0;
			shdn_pin_q   <= 1'b1;
			laser_enable <= 1'b0;
			tx_fault     <= 1'b0;
			tx_fault_oe  <= 1'b1; // no fault, so the open collector pulls low
			receive_signal_lost <= 1'b1;
		end else begin
			shdn_pin_q   <= shdn_pin;
			fault_latch  <= next_fault;
			laser_enable <= ~shdn_eff & ~next_fault;
			tx_fault     <= next_fault;
			tx_fault_oe  <= ~next_fault; // open collector: pull low when no fault
			receive_signal_lost <= los_s;
		end
	end

	// ************************************************
	// two-wire slave, eeprom style
	// ************************************************
	logic scl_q;
	logic sda_q;
	wire  scl_rise = scl_s & ~scl_q;
	wire  scl_fall = ~scl_s & scl_q;
	wire  start_c  = scl_s & sda_q & ~sda_s;
	wire  stop_c   = scl_s & ~sda_q & sda_s;

	oxm_pkg::oxm_state_t state;
	logic [7:0] shift;
	logic [2:0] bit_cnt;
	logic [7:0] word_addr;
	logic       page;
	logic       rd_mode;
	logic [7:0] mem_rdata;

	// at byte_done the r/w bit is still on sda_s, so address bits 7:1 sit in shift[6:0]
	wire dev_id   = {shift[6:0], 1'b0} == oxm_pkg::ADDR_ID;
	wire dev_diag = {shift[6:0], 1'b0} == oxm_pkg::ADDR_DIAG;
	wire byte_done = scl_rise && bit_cnt == oxm_pkg::BITS_PER_BYTE_M1;
	wire at_trsc  = page && word_addr == oxm_pkg::OFF_TRSC;

	// status byte is built live; measurements are served live too
	wire [7:0] trsc_byte = {shdn_eff, soft_shdn, 3'h0, fault_latch,
	                        receive_signal_lost, 1'b0};
	logic [7:0] rd_byte;
	always_comb begin
		rd_byte = mem_rdata;
		if (page) begin
			if (word_addr == oxm_pkg::OFF_TRSC) rd_byte = trsc_byte;
			else if (word_addr == oxm_pkg::OFF_TEMP) rd_byte = meas.temp[15:8];
			else if (word_addr == oxm_pkg::OFF_TEMP + 8'h01) rd_byte = meas.temp[7:0];
			else if (word_addr == oxm_pkg::OFF_VCC) rd_byte = meas.vcc[15:8];
			else if (word_addr == oxm_pkg::OFF_VCC + 8'h01) rd_byte = meas.vcc[7:0];
			else if (word_addr == oxm_pkg::OFF_BIAS) rd_byte = meas.bias[15:8];
			else if (word_addr == oxm_pkg::OFF_BIAS + 8'h01) rd_byte = meas.bias[7:0];
			else if (word_addr == oxm_pkg::OFF_TXPWR) rd_byte = meas.tx_pwr[15:8];
			else if (word_addr == oxm_pkg::OFF_TXPWR + 8'h01) rd_byte = meas.tx_pwr[7:0];
			else if (word_addr == oxm_pkg::OFF_RXPWR) rd_byte = meas.rx_pwr[15:8];
			else if (word_addr == oxm_pkg::OFF_RXPWR + 8'h01) rd_byte = meas.rx_pwr[7:0];
		end
	end

	oxm_pkg::oxm_mem_req_t mem_req;
	wire mem_we = state == oxm_pkg::ST_WDATA && byte_done;
	assign mem_req.we    = mem_we;
	assign mem_req.page  = page;
	assign mem_req.addr  = word_addr;
	assign mem_req.wdata = {shift[6:0], sda_s};

	oxm_mem u_mem (
		.clk_sys   (clk_sys),
		.req       (mem_req),
		.req_valid (mem_we),
		.rdata     (mem_rdata)
	);

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			scl_q     <= 1'b1;
			sda_q     <= 1'b1;
			state     <= oxm_pkg::ST_IDLE;
			shift     <= 8'h00;
			bit_cnt   <= 3'h0;
			word_addr <= 8'h00;
			page      <= 1'b0;
			rd_mode   <= 1'b0;
			soft_shdn <= 1'b0;
			sda_o     <= 1'b0;
			sda_oe    <= 1'b0;
		end else begin
			scl_q <= scl_s;
			sda_q <= sda_s;
			if (start_c) begin
				state   <= oxm_pkg::ST_DEV;
				bit_cnt <= 3'h0;
				sda_oe  <= 1'b0;
			end else if (stop_c) begin
				state  <= oxm_pkg::ST_IDLE;
				sda_oe <= 1'b0;
			end else begin
				if (scl_rise) begin
					shift   <= {shift[6:0], sda_s};
					bit_cnt <= bit_cnt + 3'h1;
				end
				case (state)
				oxm_pkg::ST_DEV: begin
					if (byte_done) begin
						shift <= {shift[6:0], sda_s};
						if (dev_id || dev_diag) begin
							page    <= dev_diag;
							rd_mode <= sda_s;
							state   <= oxm_pkg::ST_DACK;
						end else begin
							state <= oxm_pkg::ST_IDLE;
						end
					end
				end
				oxm_pkg::ST_DACK, oxm_pkg::ST_WACK: begin
					if (scl_fall && !sda_oe) begin
						sda_o  <= 1'b0;
						sda_oe <= 1'b1;
					end else if (scl_fall) begin
						bit_cnt <= 3'h0;
						sda_oe  <= 1'b0;
						if (rd_mode) begin
							state  <= oxm_pkg::ST_RDATA;
							// each scl rise shifts left, so the next bit is shift[7]
							shift  <= rd_byte;
							sda_o  <= rd_byte[7];
							sda_oe <= ~rd_byte[7];
						end else begin
							state <= state == oxm_pkg::ST_DACK ? oxm_pkg::ST_WORD
							                                   : oxm_pkg::ST_WDATA;
						end
						if (rd_mode) word_addr <= word_addr + 8'h01;
					end
				end
				oxm_pkg::ST_WORD: begin
					if (byte_done) begin
						word_addr <= {shift[6:0], sda_s};
						state     <= oxm_pkg::ST_WACK;
					end
				end
				oxm_pkg::ST_WDATA: begin
					if (byte_done) begin
						if (at_trsc) soft_shdn <= shift[oxm_pkg::BIT_SHDN_SOFT - 1];
						word_addr <= word_addr + 8'h01;
						state     <= oxm_pkg::ST_WACK;
					end
				end
				oxm_pkg::ST_RDATA: begin
					if (scl_fall) begin
						if (bit_cnt == 3'h0) begin
							sda_oe <= 1'b0;
							state  <= oxm_pkg::ST_RACK;
						end else begin
							sda_o  <= shift[7];
							sda_oe <= ~shift[7];
						end
					end
				end
				oxm_pkg::ST_RACK: begin
					// master nack ends the burst; ack continues with next byte
					if (scl_rise && sda_s) begin
						state <= oxm_pkg::ST_IDLE;
					end else if (scl_fall) begin
						state     <= oxm_pkg::ST_RDATA;
						bit_cnt   <= 3'h0;
						shift     <= rd_byte;
						sda_o     <= rd_byte[7];
						sda_oe    <= ~rd_byte[7];
						word_addr <= word_addr + 8'h01;
					end
				end
				default: begin
					state <= oxm_pkg::ST_IDLE;
				end
				endcase
			end
		end
	end
endmodule

// ===== tb/oxm_chk.sv
/* oxm_chk: port assertions of oxm_top.
   assumes one clk_sys domain, rst_b synchronous active low. */
`timescale 1ns/100ps
module oxm_chk (
	input	wire logic	clk_sys,
	input	wire logic	rst_b,
	input	wire logic	tx_shutdown_pin,
	input	wire logic	tx_shutdown_pin_driven,
	input	wire logic	laser_fault_det,
	input	wire logic	unsafe_power_det,
	input	wire logic	optical_input_bad,
	input	wire logic	sda_o,
	input	wire logic	sda_oe,
	input	wire logic	laser_enable,
	input	wire logic	tx_fault,
	input	wire logic	tx_fault_oe,
	input	wire logic	receive_signal_lost
);
	// ****
	// pin relations, four edges cover the two-flop sync
	// ****
	wire	sd_hw = tx_shutdown_pin | ~tx_shutdown_pin_driven;
	// an eye-safety trip latches the fault output as well
	wire	trip_in = laser_fault_det | unsafe_power_det;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	a_pin_off: assert property (tx_shutdown_pin[*4] |-> !laser_enable)
		else $error("laser on with shutdown pin high");
	a_float_off: assert property (!tx_shutdown_pin_driven[*4] |-> !laser_enable)
		else $error("laser on with shutdown pin floating");
	a_fault_sets: assert property (laser_fault_det[*4] |-> tx_fault && !laser_enable)
		else $error("fault not latched");
	a_fault_cause: assert property ($rose(tx_fault) |-> $past(trip_in, 3))
		else $error("fault raised without cause");
	// one edge of slack either way on the clear latency
	a_fault_clear: assert property ($fell(tx_fault) |->
		!$past(sd_hw, 2) && ($past(sd_hw, 4) || $past(sd_hw, 5)))
		else $error("fault cleared without shutdown toggle");
	a_unsafe_off: assert property (unsafe_power_det[*4] |-> !laser_enable)
		else $error("laser on while unsafe");
	a_los_set: assert property (optical_input_bad[*4] |-> receive_signal_lost)
		else $error("loss flag low with bad input");
	a_los_clr: assert property (!optical_input_bad[*4] |-> !receive_signal_lost)
		else $error("loss flag high with good input");
	a_oe_pair: assert property (tx_fault_oe != tx_fault)
		else $error("fault enable disagrees with fault");
	a_sda_low: assert property (sda_oe |-> !sda_o)
		else $error("serial data driven high");
	cover property ($rose(tx_fault));
	cover property ($fell(tx_fault));
	cover property ($rose(sda_oe));
endmodule
bind oxm_top oxm_chk u_oxm_chk (.clk_sys(clk_sys), .rst_b(rst_b),
	.tx_shutdown_pin(tx_shutdown_pin), .tx_shutdown_pin_driven(tx_shutdown_pin_driven),
	.laser_fault_det(laser_fault_det), .unsafe_power_det(unsafe_power_det),
	.optical_input_bad(optical_input_bad), .sda_o(sda_o), .sda_oe(sda_oe),
	.laser_enable(laser_enable), .tx_fault(tx_fault), .tx_fault_oe(tx_fault_oe),
	.receive_signal_lost(receive_signal_lost));

// ===== tb/oxm_host.sv
/* oxm_host: board controller as two-wire master.
   assumes a pull-up on sda; scl stands high between frames. */
`timescale 1ns/100ps
module oxm_host (
	input	wire logic	clk_sys,
	input	wire logic	sda,
	output	logic	scl,
	output	logic	sda_low
);
	// ****
	// bit level, 8 clocks per bit gives an 80 ns serial clock
	// ****
	initial begin
		scl <= 1'b1;
		sda_low <= 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	task automatic bit_io(input logic b, output logic r);
		sda_low <= ~b;
		tick(2);
		scl <= 1'b1;
		tick(2);
		@(negedge clk_sys);
		r = sda;
		tick(2);
		scl <= 1'b0;
		tick(2);
	endtask
	// data changes only while scl is low, except at start and stop
	task automatic start();
		sda_low <= 1'b0;
		tick(2);
		scl <= 1'b1;
		tick(4);
		sda_low <= 1'b1;
		tick(4);
		scl <= 1'b0;
		tick(2);
	endtask
	task automatic stop();
		sda_low <= 1'b1;
		tick(2);
		scl <= 1'b1;
		tick(4);
		sda_low <= 1'b0;
		tick(4);
	endtask
	task automatic byte_w(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(b[i], r);
		bit_io(1'b1, r);
		ack = ~r;
	endtask
	task automatic byte_r(output logic [7:0] d, input logic last);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
		bit_io(last, r);
	endtask
endmodule

// ===== tb/oxm_top_tb_top.sv
/* oxm_top_tb_top: directed bench for oxm_top.
   assumes oxm_host as master and oxm_chk bound to the top. */
`timescale 1ns/100ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin fail_count++; \
	$display("CHECK FAILED t=%0t got %h exp %h", $time, a, e); end end
module oxm_top_tb_top;
	logic	clk_sys = 1'b0;
	logic	rst_b, pin, drv, flt, uns, bad, scl, host_low, sda_o, sda_oe;
	logic	laser_enable, tx_fault, tx_fault_oe, los, ack;
	logic [7:0]	d;
	int	fail_count = 0;
	int	total_checks = 0;
	oxm_pkg::oxm_meas_t	meas;
	wire	sda = ~((sda_oe & ~sda_o) | host_low);
	always #5 clk_sys = ~clk_sys;
	oxm_top u_oxm_top (.clk_sys(clk_sys), .rst_b(rst_b), .tx_shutdown_pin(pin),
		.tx_shutdown_pin_driven(drv), .laser_fault_det(flt), .unsafe_power_det(uns),
		.optical_input_bad(bad), .meas(meas), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
		.sda_oe(sda_oe), .laser_enable(laser_enable), .tx_fault(tx_fault),
		.tx_fault_oe(tx_fault_oe), .receive_signal_lost(los));
	oxm_host u_oxm_host (.clk_sys(clk_sys), .sda(sda), .scl(scl), .sda_low(host_low));
	// ****
	// tasks
	// ****
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	task automatic wr(input logic [7:0] dev, off, dat, output logic a);
		logic x;
		u_oxm_host.start();
		u_oxm_host.byte_w(dev, a);
		u_oxm_host.byte_w(off, x);
		u_oxm_host.byte_w(dat, x);
		u_oxm_host.stop();
	endtask
	task automatic rd(input logic [7:0] dev, off, output logic [7:0] q);
		logic x;
		u_oxm_host.start();
		u_oxm_host.byte_w(dev, x);
		u_oxm_host.byte_w(off, x);
		u_oxm_host.start();
		u_oxm_host.byte_w(dev | 8'h01, x);
		u_oxm_host.byte_r(q, 1'b1);
		u_oxm_host.stop();
	endtask
	task automatic tdone(input string s);
		$display("test %s done", s);
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		cyc(100000);
		fail_count++;
		print_verdict();
	end
	// ****
	// tests; shutdown spacing is far below 10 ms to keep the run short
	// ****
	initial begin
		{rst_b, pin, drv, flt, uns, bad} <= 6'h00;
		meas <= 80'h1234_5678_9ABC_DEF0_0F1E;
		cyc(5);
		rst_b <= 1'b1;
		cyc(6);
		`CHK(laser_enable, 1'b0)
		drv <= 1'b1;
		cyc(6);
		`CHK(laser_enable, 1'b1)
		`CHK(los, 1'b0)
		tdone("pins");
		wr(8'hA2, oxm_pkg::OFF_TRSC, 8'h40, ack);
		cyc(6);
		`CHK(laser_enable, 1'b0)
		rd(8'hA2, oxm_pkg::OFF_TRSC, d);
		`CHK(d, 8'hC0)
		wr(8'hA2, oxm_pkg::OFF_TRSC, 8'h00, ack);
		cyc(6);
		`CHK(laser_enable, 1'b1)
		bad <= 1'b1;
		cyc(6);
		`CHK(los, 1'b1)
		rd(8'hA2, oxm_pkg::OFF_TRSC, d);
		`CHK(d, 8'h02)
		bad <= 1'b0;
		tdone("status");
		rd(8'hA2, oxm_pkg::OFF_TEMP, d);
		`CHK(d, 8'h12)
		rd(8'hA2, 8'h69, d);
		`CHK(d, 8'h1E)
		u_oxm_host.start();
		u_oxm_host.byte_w(8'hA2, ack);
		u_oxm_host.byte_w(8'h68, ack);
		u_oxm_host.start();
		u_oxm_host.byte_w(8'hA3, ack);
		u_oxm_host.byte_r(d, 1'b0);
		`CHK(d, 8'h0F)
		u_oxm_host.byte_r(d, 1'b1);
		`CHK(d, 8'h1E)
		u_oxm_host.stop();
		wr(8'hA0, 8'h10, 8'h5A, ack);
		`CHK(ack, 1'b1)
		rd(8'hA0, 8'h10, d);
		`CHK(d, 8'h5A)
		wr(8'hB0, 8'h10, 8'h5A, ack);
		`CHK(ack, 1'b0)
		tdone("serial");
		flt <= 1'b1;
		cyc(6);
		flt <= 1'b0;
		`CHK({tx_fault, laser_enable}, 2'b10)
		`CHK(tx_fault_oe, 1'b0)
		cyc(20);
		`CHK(tx_fault, 1'b1)
		rd(8'hA2, oxm_pkg::OFF_TRSC, d);
		`CHK(d, 8'h04)
		pin <= 1'b1;
		cyc(6);
		`CHK(laser_enable, 1'b0)
		pin <= 1'b0;
		cyc(6);
		`CHK({tx_fault, laser_enable}, 2'b01)
		tdone("fault");
		uns <= 1'b1;
		cyc(6);
		`CHK(laser_enable, 1'b0)
		tdone("unsafe");
		print_verdict();
	end
endmodule
